// File: tci_pkg.sv
// package for the connector port interrupt and init block
// assumes a plain register port with read data one cycle after the strobe
package tci_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_INT = 4'h2;
   // control field positions
   localparam int CTRL_INT_MASK = 0;
   localparam int CTRL_CUR_LO = 1;
   localparam int CTRL_CUR_HI = 2;
   localparam int CTRL_ROLE_LO = 4;
   localparam int CTRL_ROLE_HI = 5;
   // status field positions
   localparam int STAT_BUS_OK = 0;
   localparam int STAT_INT_PEND = 1;
   // interrupt flag positions
   localparam int INT_BUS_OK = 0;
   localparam int INT_EXT = 1;
   localparam int NUM_EXT = 6;
   // roles
   typedef enum logic [1:0]
   {
      ROLE_SINK = 2'b00,
      ROLE_SOURCE = 2'b01,
      ROLE_DRP = 2'b10,
      ROLE_ACC = 2'b11
   } tci_role_t;
   // source current advertisement
   typedef enum logic [1:0]
   {
      CUR_OFF = 2'b00,
      CUR_DEFAULT = 2'b01,
      CUR_1P5A = 2'b10,
      CUR_3A = 2'b11
   } tci_cur_t;
   typedef struct packed
   {
      logic src_current_sel_hi;
      logic src_current_sel_lo;
   } tci_cur_sel_t;
   typedef struct packed
   {
      logic adv_default;
      logic adv_1p5a;
      logic adv_3a;
   } tci_adv_t;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam logic [7:0] ZERO8 = 8'h00;
endpackage : tci_pkg

// File: tci_port_int.sv
// interrupt, power-up defaults and current advertisement decode
// assumes synchronous inputs and one clock; interrupt pin is open drain
`timescale 1ns/1ps
// What this block does
// - power up as sink, all interrupts masked
// - pin released, global mask set at reset
// - unmasking asserts the pin only when a flag is pending
// - event drives pin low, read releases
// - mask set keeps pin released
// - masked events held, pin low on unmask
// - decode 01 default, 10 1.5A, 11 3A
// - supply valid comparator raises supply event
module tci_port_int
   import tci_pkg::*;
#(
   parameter int N_EXT = NUM_EXT
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [DATA_W-1:0] rdata_out,
   input wire logic bus_supply_valid_in,
   input wire logic [N_EXT-1:0] event_in,
   output logic int_n_out,
   output logic int_oe_out,
   output tci_role_t role_out,
   output tci_adv_t adv_out
);
   // reset release pair; nothing but rst_sync reads rst_meta
   logic rst_meta;
   logic rst_sync;
   logic next_rst_meta;
   logic next_rst_sync;
   // control register: mask, current setting, role
   logic [DATA_W-1:0] ctrl;
   logic [DATA_W-1:0] next_ctrl;
   logic ctrl_wr;
   // sticky flags: bit 0 supply, the rest external events
   logic [N_EXT:0] flags;
   wire logic [N_EXT:0] next_flags;
   logic [N_EXT:0] flag_set;
   logic flag_clr;
   logic any_flag;
   // supply edge detect
   logic supply_prev;
   logic next_supply_prev;
   logic bus_supply_ok_event;
   // read port and its address decode
   logic [DATA_W-1:0] next_rdata;
   logic rd_ctrl;
   logic rd_status;
   logic rd_int;
   // interrupt pin, open drain
   logic next_oe;
   logic next_int_n;
   // role and advertisement
   tci_role_t next_role;
   tci_adv_t next_adv;
   tci_cur_sel_t cur_sel;

   // strobe plus address match, shared by every register
   function automatic logic is_read(input logic rd,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
      is_read = rd && (a == r);
   endfunction : is_read

   function automatic logic is_write(input logic wr,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] r);
      is_write = wr && (a == r);
   endfunction : is_write

   // set wins over the read clear in the same cycle,
   // so an event landing on the read is never lost
   function automatic logic flag_next(input logic cur,
                                      input logic clr,
                                      input logic set);
      flag_next = (cur && !clr) || set;
   endfunction : flag_next

   // reset release: asynchronous assert, two-flop release
   always_comb
   begin
      next_rst_meta = 1'b1;
      next_rst_sync = rst_meta;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= next_rst_meta;
         rst_sync <= next_rst_sync;
      end
   end

   // supply rising edge
   // prev resets low, so a supply already up at release counts
   assign bus_supply_ok_event = bus_supply_valid_in && !supply_prev;

   always_comb
   begin
      next_supply_prev = bus_supply_valid_in;
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         supply_prev <= 1'b0;
      end
      else
      begin
         supply_prev <= next_supply_prev;
      end
   end

   always_comb
   begin
      ctrl_wr = is_write(wr_in, addr_in, REG_CTRL);
      next_ctrl = ctrl;
      if (ctrl_wr)
      begin
         next_ctrl = wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         ctrl <= CTRL_RESET;
      end
      else
      begin
         ctrl <= next_ctrl;
      end
   end

   always_comb
   begin
      flag_clr = is_read(rd_in, addr_in, REG_INT);
      flag_set = '0;
      flag_set[INT_BUS_OK] = bus_supply_ok_event;
      flag_set[N_EXT:INT_EXT] = event_in;
      any_flag = |flags;
   end

   // flags latch whatever the mask
   // the mask only gates the pin
   for (genvar i = 0; i <= N_EXT; i++)
   begin : g_flag
      assign next_flags[i] = flag_next(flags[i], flag_clr, flag_set[i]);
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         flags <= '0;
      end
      else
      begin
         flags <= next_flags;
      end
   end

   // unmapped reads and reserved status and interrupt bits return zero
   always_comb
   begin
      rd_ctrl = is_read(rd_in, addr_in, REG_CTRL);
      rd_status = is_read(rd_in, addr_in, REG_STATUS);
      rd_int = is_read(rd_in, addr_in, REG_INT);
      next_rdata = ZERO8;
      if (rd_ctrl)
      begin
         next_rdata = ctrl;
      end
      else if (rd_status)
      begin
         next_rdata[STAT_BUS_OK] = bus_supply_valid_in;
         next_rdata[STAT_INT_PEND] = any_flag;
      end
      else if (rd_int)
      begin
         next_rdata[N_EXT:0] = flags;
      end
   end

   // read data stand for one cycle only, then fall back to zero
   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         rdata_out <= ZERO8;
      end
      else
      begin
         rdata_out <= next_rdata;
      end
   end

   // nothing pending, stays released
   // next values, so a read or unmask acts in one cycle
   // limitation: an event in the read cycle keeps the pin low
   always_comb
   begin
      next_oe = (|next_flags) && !next_ctrl[CTRL_INT_MASK];
      // open drain: the data side only ever drives low
      next_int_n = 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         int_oe_out <= 1'b0;
         int_n_out <= 1'b0;
      end
      else
      begin
         int_oe_out <= next_oe;
         int_n_out <= next_int_n;
      end
   end

   // advertisement decode
   // all four codes are legal, so no default arm
   always_comb
   begin
      cur_sel.src_current_sel_hi = ctrl[CTRL_CUR_HI];
      cur_sel.src_current_sel_lo = ctrl[CTRL_CUR_LO];
      next_adv = '0;
      unique case (tci_cur_t'(cur_sel))
         CUR_OFF:
         begin
            next_adv = '0;
         end
         CUR_DEFAULT:
         begin
            next_adv.adv_default = 1'b1;
         end
         CUR_1P5A:
         begin
            next_adv.adv_1p5a = 1'b1;
         end
         CUR_3A:
         begin
            next_adv.adv_3a = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         // no advertisement until software picks one
         adv_out <= '0;
      end
      else
      begin
         adv_out <= next_adv;
      end
   end

   // role field follows the control register directly
   always_comb
   begin
      next_role = tci_role_t'(next_ctrl[CTRL_ROLE_HI:CTRL_ROLE_LO]);
   end

   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         role_out <= ROLE_SINK;
      end
      else
      begin
         role_out <= next_role;
      end
   end
endmodule : tci_port_int

// File: tci_host_model.sv
// host side of the interrupt line
// assumes one open-drain driver, the block, and a pull-up
`timescale 1ns/1ps
module tci_host_model
(
   input wire logic int_n_in,
   input wire logic int_oe_in,
   output logic line_out
);
   assign line_out = int_oe_in ? int_n_in : 1'b1;
endmodule : tci_host_model

// File: tci_port_int_properties.sv
// checker bound onto tci_port_int
// assumes one clock and strobes from a plain register port
`timescale 1ns/1ps
module tci_port_int_properties
   import tci_pkg::*;
#(parameter int N_EXT = NUM_EXT)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic bus_supply_valid_in,
   input wire logic [N_EXT-1:0] event_in,
   input wire logic int_oe_out
);
   logic m;
   logic any_evt;
   assign any_evt = |event_in;
   always_ff @(posedge clk_in or negedge resetn_in)
      if (!resetn_in)
         m <= 1'b1;
      else if (wr_in && addr_in == REG_CTRL)
         m <= wdata_in[CTRL_INT_MASK];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   property p_rel; $rose(resetn_in) |-> !int_oe_out [*3]; endproperty
   a_rel: assert property (p_rel) else $error("irq at reset");
   property p_msk; m |-> !int_oe_out; endproperty
   a_msk: assert property (p_msk) else $error("irq masked");
   property p_evt; |event_in && !m && !wr_in |=> int_oe_out; endproperty
   a_evt: assert property (p_evt) else $error("irq missed");
   property p_sup; $rose(bus_supply_valid_in) && !m && !wr_in |=> int_oe_out;
   endproperty
   a_sup: assert property (p_sup) else $error("supply missed");
   property p_clr; rd_in && addr_in == REG_INT && !(|event_in)
      && !$rose(bus_supply_valid_in) |=> !int_oe_out; endproperty
   a_clr: assert property (p_clr) else $error("irq kept");
   property p_rise; $rose(int_oe_out)
      |-> $past(any_evt) || $past(bus_supply_valid_in) || $past(wr_in);
   endproperty
   a_rise: assert property (p_rise) else $error("irq uncaused");
   property p_hold; int_oe_out && !rd_in && !wr_in |=> int_oe_out; endproperty
   a_hold: assert property (p_hold) else $error("irq lost");
   property p_flg; rd_in && addr_in == REG_INT && int_oe_out |=> |rdata_out;
   endproperty
   a_flg: assert property (p_flg) else $error("flags lost");
   c_irq: cover property ($rose(int_oe_out));
   c_sup: cover property ($rose(bus_supply_valid_in));
   c_clr: cover property (rd_in && addr_in == REG_INT && int_oe_out);
endmodule : tci_port_int_properties
bind tci_port_int tci_port_int_properties #(.N_EXT(N_EXT)) chk_u (.clk_in,
   .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .bus_supply_valid_in, .event_in, .int_oe_out);

// File: tci_port_int_bench.sv
// bench for tci_port_int: register port, supply and event stimulus
// assumes package, host model and checker are compiled first
`timescale 1ns/1ps
module tci_port_int_bench
   import tci_pkg::*;
;
   typedef struct {logic w, r; logic [3:0] a; logic [7:0] d; logic s;
      logic [5:0] e; logic l;} tci_row_t;
   tci_row_t rows [14] = '{
      '{0,1,REG_CTRL,8'h01,0,6'h00,1}, '{1,0,REG_CTRL,8'h12,0,6'h00,1},
      '{0,1,REG_CTRL,8'h12,0,6'h00,1}, '{1,0,REG_CTRL,8'h24,0,6'h00,1},
      '{0,1,REG_CTRL,8'h24,0,6'h00,1}, '{1,0,REG_CTRL,8'h36,0,6'h00,1},
      '{0,0,REG_CTRL,8'h00,1,6'h00,0}, '{0,1,REG_INT,8'h01,1,6'h00,1},
      '{0,0,REG_CTRL,8'h00,1,6'h20,0}, '{1,0,REG_CTRL,8'h37,1,6'h00,1},
      '{0,0,REG_CTRL,8'h00,1,6'h01,1}, '{0,1,REG_STATUS,8'h03,1,6'h00,1},
      '{1,0,REG_CTRL,8'h36,1,6'h00,0}, '{0,1,REG_INT,8'h42,1,6'h00,1}};
   logic clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, line;
   logic bus_supply_valid_in = 0, int_n_out, int_oe_out;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00, rdata_out, ctl = CTRL_RESET;
   logic [5:0] event_in = 6'h00;
   tci_role_t role_out;
   tci_adv_t adv_out;
   int err_count = 0, checked = 0;
   tci_port_int dut_u (.clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .bus_supply_valid_in, .event_in, .int_n_out,
      .int_oe_out, .role_out, .adv_out);
   tci_host_model host_u (.int_n_in(int_n_out), .int_oe_in(int_oe_out),
      .line_out(line));
   initial forever #50 clk_in = ~clk_in;
   task ck(input logic ok);
      checked++;
      err_count += int'(ok !== 1'b1);
      if (ok !== 1'b1)
         $display("mismatch at %0t: wrong value", $time);
   endtask : ck
   // one strobe or idle cycle, then the line and any read data
   task step(input tci_row_t x);
      logic [1:0] c;
      @(posedge clk_in);
      {wr_in, rd_in, addr_in, wdata_in} <= {x.w, x.r, x.a, x.d};
      {bus_supply_valid_in, event_in} <= {x.s, x.e};
      @(posedge clk_in);
      {wr_in, rd_in, event_in} <= 8'h00;
      if (x.w && x.a == REG_CTRL)
         ctl = x.d;
      c = ctl[2:1];
      #1;
      ck(line === x.l);
      if (x.r)
      begin
         ck(rdata_out === x.d);
         ck(role_out === ctl[5:4]);
         ck(adv_out === {c == 2'h1, c == 2'h2, c == 2'h3});
      end
   endtask : step
   task stop_test;
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      foreach (rows[i])
         step(rows[i]);
      // second reset with supply still up: flags must not leak out
      @(posedge clk_in);
      resetn_in <= 1'b0;
      ctl = CTRL_RESET;
      @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      step('{0,1,REG_CTRL,8'h01,1,6'h00,1});
      step('{0,1,4'hF,8'h00,1,6'h00,1});
      stop_test();
   end
endmodule : tci_port_int_bench
